// *** pkg/uir_pkg.sv ***
// Purpose: Shared constants and types for the serial transceiver channel.
// Assumes: 8-bit register port, 3-bit register index, 40 MHz clock.
// Notes:   Offsets and mode bit positions are fixed here and nowhere else.
package uir_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_MODE = 3'h0;  // async_mode_register
  localparam logic [2:0] ADDR_BAUD = 3'h1;  // baud_generator_control
  localparam logic [2:0] ADDR_TXS  = 3'h2;  // tx_shift_register (write)
  localparam logic [2:0] ADDR_RXB  = 3'h3;  // receive_buffer (read)
  localparam logic [2:0] ADDR_STAT = 3'h4;  // receive_error_status (read)

  // ---------------------------------------------------------------
  // Mode register fields
  // ---------------------------------------------------------------
  localparam int MODE_TXE    = 7;  // transmit_enable_bit
  localparam int MODE_RXE    = 6;  // receive_enable_bit
  localparam int MODE_PAR_HI = 5;  // parity type, upper bit
  localparam int MODE_PAR_LO = 4;  // parity type, lower bit
  localparam int MODE_CL8    = 3;  // 1: eight character bits
  localparam int MODE_SL2    = 2;  // 1: two stop bits
  localparam int MODE_ISRM   = 1;  // error_completion_mask_bit
  localparam int MODE_IR     = 0;  // infrared pulse mode

  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h0F;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ---------------------------------------------------------------
  // Error status codes
  // ---------------------------------------------------------------
  localparam logic [7:0] STAT_PE = 8'h04;
  localparam logic [7:0] STAT_FE = 8'h02;
  localparam logic [7:0] STAT_OE = 8'h01;

  // ---------------------------------------------------------------
  // Bit timing, in ticks of the 16x sample clock
  // ---------------------------------------------------------------
  localparam logic [4:0] TICKS_LAST   = 5'h0F;  // last tick of a bit
  localparam logic [4:0] HALF_LAST    = 5'h07;  // last tick of half a bit
  localparam logic [4:0] IR_ON_TICK   = 5'h08;  // pulse starts mid-bit
  localparam logic [4:0] IR_OFF_TICK  = 5'h0B;  // 3 ticks later it ends
  localparam logic [4:0] IR_HOLD_LEN  = 5'h10;  // stretch one bit time
  localparam logic [3:0] BITS_7       = 4'h7;
  localparam logic [3:0] BITS_8       = 4'h8;

  // ---------------------------------------------------------------
  // Absolute times
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 25000;
  localparam int IR_MIN_PULSE_PS  = 1410000;
  localparam int IR_MAX_EXTRA_PS  = 1080000;
  // Least pulse we must accept, rounded down so shorter never fails
  localparam int IR_MIN_PULSE_CYC = IR_MIN_PULSE_PS / CLK_PERIOD_PS;
  // Fixed allowance above 3/16 bit, rounded down
  localparam int IR_MAX_EXTRA_CYC = IR_MAX_EXTRA_PS / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PAR_NONE, PAR_ZERO, PAR_ODD, PAR_EVEN} uir_par_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uir_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_HALF, RX_DATA, RX_PAR, RX_STOP} uir_rx_state_t;

endpackage

// *** logic/uir_uart.sv ***
// Purpose: Asynchronous serial transceiver channel with infrared pulse mode.
// Assumes: Register port with one-cycle strobes, read data one cycle later.
// Notes:   Bit timing uses a 16x tick from an internal divider.
// Function
// - Mode register picks 7/8 character bits, parity type, 1/2 stop bits.
// - Even parity: odd count of ones including parity bit flags parity error.
// - Odd parity: even count of ones flags parity error.
// - Zero parity sends a 0 parity bit and never checks it.
// - No parity: no parity bit either way, never a parity error.
// - Writing the shift register starts sending; hardware adds framing bits.
// - Transmit completion interrupt when the shift register has emptied.
// - Receive enable starts sampling of the receive pin at baud rate.
// - Low pin starts half-bit count; low resample confirms the start bit.
// - Frame ends after data, parity and one stop bit; second stop ignored.
// - Completion moves data to the buffer, even with an error.
// - Error frames give completion interrupt only while the mask bit is 0.
// - Clearing receive enable aborts at once, keeps buffer, no interrupts.
// - Status codes: parity 04H, framing 02H, overrun 01H.
// - Error interrupt comes before the completion interrupt.
// - Status clears on buffer read or next frame; new errors set anew.
// - Infrared frames: one start, eight data, one stop bit.
// - Infrared pulse lasts 3/16 bit and starts mid-bit.
// - Infrared pulse never exceeds 3/16 bit plus tolerance.
// - Infrared receiver accepts pulses down to 1.41 us.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module uir_uart (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       serial_receive_pin,
  output logic            serial_transmit_pin,
  output logic            tx_complete_irq,
  output logic            rx_complete_irq,
  output logic            rx_error_irq
);
  import uir_pkg::*;

  // ---------------------------------------------------------------
  // Registers and configuration
  // ---------------------------------------------------------------
  logic [7:0]    mode_q;
  logic [7:0]    brg_q;
  logic [7:0]    rxb_q;
  logic [7:0]    stat_q;
  logic          rxb_full_q;
  logic [7:0]    rdata_q;
  logic          ir;
  logic          cl8;
  logic          sl2;
  uir_par_t      par;
  logic          rxe;
  logic          txe;
  logic          isrm;

  // Infrared forces the fixed 8N1 frame
  assign ir   = mode_q[MODE_IR];
  assign cl8  = ir | mode_q[MODE_CL8];
  assign sl2  = ~ir & mode_q[MODE_SL2];
  assign par  = ir ? PAR_NONE : uir_par_t'(mode_q[MODE_PAR_HI:MODE_PAR_LO]);
  assign rxe  = mode_q[MODE_RXE];
  assign txe  = mode_q[MODE_TXE];
  assign isrm = mode_q[MODE_ISRM];

  // Parity bit that makes the frame match the selected type
  function automatic logic par_bit(input logic [7:0] d, input uir_par_t p);
    case (p)
      PAR_EVEN: par_bit = ^d;
      PAR_ODD:  par_bit = ~^d;
      default:  par_bit = 1'b0;
    endcase
  endfunction

  // Mismatch only for even and odd types
  function automatic logic par_bad(input logic [7:0] d, input logic pb, input uir_par_t p);
    case (p)
      PAR_EVEN: par_bad = ^{d, pb};
      PAR_ODD:  par_bad = ~^{d, pb};
      default:  par_bad = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Baud tick divider
  // ---------------------------------------------------------------
  logic [7:0] div_q;
  logic       tick;

  assign tick = (div_q == 8'h00);

  // Tick period is control value plus one clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
    end else if (tick) begin
      div_q <= brg_q;
    end else begin
      div_q <= div_q - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  uir_tx_state_t tx_state_q;
  logic [7:0]    tx_sh_q;
  logic [4:0]    tx_tcnt_q;
  logic [3:0]    tx_bits_q;
  logic          tx_pb_q;
  logic          tx_stop2_q;
  logic          tx_load;
  logic          tx_level;
  logic          tx_bit_end;

  assign tx_load    = reg_wr && (reg_addr == ADDR_TXS) && txe && (tx_state_q == TX_IDLE);
  assign tx_bit_end = tick && (tx_tcnt_q == TICKS_LAST);

  // Frame sequencer; writes while busy are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_q <= TX_IDLE;
      tx_sh_q    <= DATA_RST;
      tx_tcnt_q  <= 5'h00;
      tx_bits_q  <= 4'h0;
      tx_pb_q    <= 1'b0;
      tx_stop2_q <= 1'b0;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          if (tx_load) begin
            tx_state_q <= TX_START;
            tx_sh_q    <= cl8 ? reg_wdata : {1'b0, reg_wdata[6:0]};
            tx_pb_q    <= par_bit(cl8 ? reg_wdata : {1'b0, reg_wdata[6:0]}, par);
            tx_bits_q  <= cl8 ? BITS_8 : BITS_7;
            tx_stop2_q <= sl2;
            tx_tcnt_q  <= 5'h00;
          end
        end
        TX_START: begin
          if (tick) tx_tcnt_q <= tx_tcnt_q + 5'h01;
          if (tx_bit_end) tx_state_q <= TX_DATA;
        end
        TX_DATA: begin
          if (tick) tx_tcnt_q <= tx_tcnt_q + 5'h01;
          if (tx_bit_end) begin
            tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
            tx_bits_q <= tx_bits_q - 4'h1;
            if (tx_bits_q == 4'h1) begin
              tx_state_q <= (par == PAR_NONE) ? TX_STOP : TX_PAR;
            end
          end
        end
        TX_PAR: begin
          if (tick) tx_tcnt_q <= tx_tcnt_q + 5'h01;
          if (tx_bit_end) tx_state_q <= TX_STOP;
        end
        TX_STOP: begin
          if (tick) tx_tcnt_q <= tx_tcnt_q + 5'h01;
          if (tx_bit_end) begin
            if (tx_stop2_q) begin
              tx_stop2_q <= 1'b0;
            end else begin
              tx_state_q <= TX_IDLE;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
      // Restart at each bit boundary; the 5-bit count would run on past 15
      if (tx_bit_end) tx_tcnt_q <= 5'h00;
    end
  end

  // Line level of the current bit
  always_comb begin
    case (tx_state_q)
      TX_START: tx_level = 1'b0;
      TX_DATA:  tx_level = tx_sh_q[0];
      TX_PAR:   tx_level = tx_pb_q;
      default:  tx_level = 1'b1;
    endcase
  end

  // Pin from a flop; infrared sends a pulse only for zero bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_transmit_pin <= 1'b1;
    end else if (ir) begin
      serial_transmit_pin <= !tx_level && (tx_tcnt_q >= IR_ON_TICK)
                             && (tx_tcnt_q < IR_OFF_TICK);
    end else begin
      serial_transmit_pin <= tx_level;
    end
  end

  // Shift register empty after the last stop bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_complete_irq <= 1'b0;
    end else begin
      tx_complete_irq <= (tx_state_q == TX_STOP) && tx_bit_end && !tx_stop2_q;
    end
  end

  // ---------------------------------------------------------------
  // Receive pin conditioning
  // ---------------------------------------------------------------
  logic       rx_s1_q;
  logic       rx_s2_q;
  logic       rx_s3_q;
  logic       rx_lvl_q;
  logic [4:0] ir_hold_q;
  logic       line;

  // Three stages; a level counts once the last two agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_q  <= 1'b1;
      rx_s2_q  <= 1'b1;
      rx_s3_q  <= 1'b1;
      rx_lvl_q <= 1'b1;
    end else begin
      rx_s1_q <= serial_receive_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q) rx_lvl_q <= rx_s3_q;
    end
  end

  // Stretch a short infrared pulse across a bit so the UART sampler sees it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_hold_q <= 5'h00;
    end else if (ir && rx_s2_q && rx_s3_q && !rx_lvl_q) begin
      ir_hold_q <= IR_HOLD_LEN;
    end else if (tick && ir_hold_q != 5'h00) begin
      ir_hold_q <= ir_hold_q - 5'h01;
    end
  end

  // Idle pin reads low in infrared mode, so the level is the pulse stretch
  assign line = ir ? (ir_hold_q == 5'h00) : rx_lvl_q;

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  uir_rx_state_t rx_state_q;
  logic [7:0]    rx_sh_q;
  logic [4:0]    rx_tcnt_q;
  logic [3:0]    rx_bits_q;
  logic          rx_pb_q;
  logic          rx_done;
  logic          rx_bit_end;
  logic [7:0]    rx_data;
  logic [7:0]    rx_err;
  logic          rxb_read;
  logic          done_pend_q;

  assign rx_bit_end = tick && (rx_tcnt_q == TICKS_LAST);
  assign rx_done    = rxe && (rx_state_q == RX_STOP) && rx_bit_end;
  assign rx_data    = cl8 ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
  assign rx_err     = (par_bad(rx_data, rx_pb_q, par) ? STAT_PE : 8'h00)
                    | (line ? 8'h00 : STAT_FE)
                    | (rxb_full_q ? STAT_OE : 8'h00);
  assign rxb_read   = reg_rd && (reg_addr == ADDR_RXB);

  // Start detection, sampling and frame assembly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_q <= RX_IDLE;
      rx_sh_q    <= DATA_RST;
      rx_tcnt_q  <= 5'h00;
      rx_bits_q  <= 4'h0;
      rx_pb_q    <= 1'b0;
    end else if (!rxe) begin
      rx_state_q <= RX_IDLE;
      rx_tcnt_q  <= 5'h00;
    end else begin
      case (rx_state_q)
        RX_IDLE: begin
          if (!line) begin
            rx_state_q <= RX_HALF;
            rx_tcnt_q  <= 5'h00;
          end
        end
        RX_HALF: begin
          if (tick) rx_tcnt_q <= rx_tcnt_q + 5'h01;
          if (tick && rx_tcnt_q == HALF_LAST) begin
            rx_tcnt_q  <= 5'h00;
            rx_bits_q  <= cl8 ? BITS_8 : BITS_7;
            rx_state_q <= line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (tick) rx_tcnt_q <= rx_tcnt_q + 5'h01;
          if (rx_bit_end) begin
            rx_sh_q   <= {line, rx_sh_q[7:1]};
            rx_bits_q <= rx_bits_q - 4'h1;
            if (rx_bits_q == 4'h1) begin
              rx_state_q <= (par == PAR_NONE) ? RX_STOP : RX_PAR;
            end
          end
        end
        RX_PAR: begin
          if (tick) rx_tcnt_q <= rx_tcnt_q + 5'h01;
          if (rx_bit_end) begin
            rx_pb_q    <= line;
            rx_state_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (tick) rx_tcnt_q <= rx_tcnt_q + 5'h01;
          if (rx_bit_end) rx_state_q <= RX_IDLE;
        end
        default: rx_state_q <= RX_IDLE;
      endcase
      // Every sampled bit lasts sixteen ticks, not thirty-two
      if (rx_bit_end) rx_tcnt_q <= 5'h00;
    end
  end

  // Buffer, status and full flag; a new frame wins over a same-cycle read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxb_q      <= DATA_RST;
      stat_q     <= 8'h00;
      rxb_full_q <= 1'b0;
    end else if (rx_done) begin
      rxb_q      <= rx_data;
      stat_q     <= rx_err;
      rxb_full_q <= 1'b1;
    end else if (rxb_read) begin
      stat_q     <= 8'h00;
      rxb_full_q <= 1'b0;
    end
  end

  // Error pulse at completion, completion pulse one clock later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_error_irq    <= 1'b0;
      done_pend_q     <= 1'b0;
      rx_complete_irq <= 1'b0;
    end else begin
      rx_error_irq    <= rx_done && (rx_err != 8'h00);
      done_pend_q     <= rx_done && !((rx_err != 8'h00) && isrm);
      rx_complete_irq <= done_pend_q;
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  // Software writes; mode changes mid-frame are its responsibility
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_RST;
      brg_q  <= BAUD_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_MODE) mode_q <= reg_wdata;
      if (reg_addr == ADDR_BAUD) brg_q  <= reg_wdata;
    end
  end

  // Read data stands one cycle; unmapped reads return zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_MODE: rdata_q <= mode_q;
        ADDR_BAUD: rdata_q <= brg_q;
        ADDR_RXB:  rdata_q <= rxb_q;
        ADDR_STAT: rdata_q <= stat_q;
        default:   rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [15:0] ir_len_q;
  logic [15:0] ir_limit;

  // Cycles the infrared pulse has been high so far
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_len_q <= 16'h0000;
    end else if (serial_transmit_pin && ir) begin
      ir_len_q <= ir_len_q + 16'h0001;
    end else begin
      ir_len_q <= 16'h0000;
    end
  end

  // Three ticks plus the fixed allowance
  assign ir_limit = 16'(3 * (int'(brg_q) + 1) + IR_MAX_EXTRA_CYC);

  sequence s_tx_load;
    tx_load;
  endsequence

  sequence s_err_done;
    rx_error_irq && !isrm ##1 rx_complete_irq;
  endsequence

  a_tx_load_start: assert property (@(posedge clk) disable iff (!rst_n)
    s_tx_load |=> (tx_state_q == TX_START) ##1 !serial_transmit_pin || ir)
    else $error("write to shift register did not start a frame");

  a_tx_done_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    tx_complete_irq |-> (tx_state_q == TX_IDLE) && ($past(tx_state_q) == TX_STOP))
    else $error("transmit completion without an emptied shift register");

  a_err_then_done: assert property (@(posedge clk) disable iff (!rst_n)
    rx_error_irq && !isrm |-> s_err_done)
    else $error("completion did not follow the error interrupt");

  a_masked_done: assert property (@(posedge clk) disable iff (!rst_n)
    rx_error_irq && isrm |=> !rx_complete_irq)
    else $error("masked error frame raised completion");

  a_even_parity: assert property (@(posedge clk) disable iff (!rst_n)
    rx_done && par == PAR_EVEN && ^{rx_data, rx_pb_q} |=> stat_q[2] && rx_error_irq)
    else $error("even parity mismatch not flagged");

  a_no_parity_err: assert property (@(posedge clk) disable iff (!rst_n)
    rx_done && (par == PAR_NONE || par == PAR_ZERO) |=> stat_q[2] == 1'b0)
    else $error("parity error flagged without parity checking");

  a_overrun_flag: assert property (@(posedge clk) disable iff (!rst_n)
    rx_done && rxb_full_q |=> stat_q[0] && rxb_full_q)
    else $error("overrun not reported");

  a_abort_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(rxe) |=> (rx_state_q == RX_IDLE) && !rx_error_irq && $stable(rxb_q))
    else $error("receive disable did not abort quietly");

  a_start_reject: assert property (@(posedge clk) disable iff (!rst_n)
    rxe && rx_state_q == RX_HALF && tick && rx_tcnt_q == HALF_LAST && line
    |=> rx_state_q == RX_IDLE)
    else $error("high resample did not cancel the start bit");

  a_ir_pulse_max: assert property (@(posedge clk) disable iff (!rst_n)
    ir && serial_transmit_pin |-> ir_len_q < ir_limit)
    else $error("infrared pulse too long");

endmodule

// *** verification/uir_peer.sv ***
// Purpose: Remote serial peer facing the channel's pins.
// Assumes: Baud value 01H, so one bit lasts 32 clocks.
// Notes:   Line idles high; bits change just after a clock edge.
//          Sent bits last 31 clocks, about 3 percent fast, so a low stop
//          bit ends well before the receiver's next start check.
`timescale 1ns/1ps
module uir_peer (
  input  wire logic clk,
  input  wire logic tx_line,
  output logic      rx_line
);
  // Idle mark level until a frame is sent
  initial rx_line = 1'b1;

  // Send a frame, bits[0] first; caller builds the framing
  task automatic send(input logic [10:0] bits);
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      rx_line <= bits[i];
      repeat (30) @(posedge clk);
    end
    @(posedge clk);
    rx_line <= 1'b1;
  endtask

  // Infrared frame: a six-clock high pulse at mid-bit for each zero bit
  task automatic ir_send(input logic [9:0] bits);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rx_line <= 1'b0;
      repeat (15) @(posedge clk);
      rx_line <= !bits[i];
      repeat (6) @(posedge clk);
      rx_line <= 1'b0;
      repeat (9) @(posedge clk);
    end
  endtask

  // Sample eleven bits at mid-bit, from the start edge
  task automatic grab(output logic [10:0] bits);
    @(negedge tx_line);
    repeat (16) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      bits[i] = tx_line;
      repeat (32) @(posedge clk);
    end
  endtask
endmodule

// *** verification/tb_uart_rx_tx_with_ir_mode.sv ***
// Purpose: Self-checking bench for the serial transceiver channel.
// Assumes: Baud value 01H, one bit is 32 clocks.
// Notes:   Irq pulses are counted by a monitor; expected counts kept here.
`timescale 1ns/1ps
module tb_uart_rx_tx_with_ir_mode;
  import uir_pkg::*;
  logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic        tx_pin, rx_pin, irq_t, irq_r, irq_e, tx_prev;
  logic [2:0]  reg_addr = '0;
  logic [7:0]  reg_wdata = '0, reg_rdata, d, x;
  logic [10:0] got;
  int          error_cnt = 0, check_count = 0, cyc = 0, n_t = 0, n_r = 0, n_e = 0;
  int          t_e = 0, t_r = 0, ir_on = 0, n_rise = 0, n_high = 0, ne = 0, nr = 0;

  always #12.5 clk = ~clk;

  uir_uart uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_receive_pin(rx_pin),
    .serial_transmit_pin(tx_pin), .tx_complete_irq(irq_t), .rx_complete_irq(irq_r),
    .rx_error_irq(irq_e));
  uir_peer peer (.clk(clk), .tx_line(tx_pin), .rx_line(rx_pin));

  // Count irq pulses and infrared pulses as the design drives them
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tx_prev <= tx_pin;
    if (irq_t === 1'b1) n_t <= n_t + 1;
    if (irq_e === 1'b1) begin
      n_e <= n_e + 1;
      t_e <= cyc;
    end
    if (irq_r === 1'b1) begin
      n_r <= n_r + 1;
      t_r <= cyc;
    end
    if (ir_on != 0 && tx_pin === 1'b1) n_high <= n_high + 1;
    if (ir_on != 0 && tx_pin === 1'b1 && tx_prev === 1'b0) n_rise <= n_rise + 1;
  end

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // Frame: start, data, bit 9 as given, then a mark bit; settle after
  task automatic fr(input logic [7:0] v, input logic b9);
    peer.send({1'b1, b9, v, 1'b0});
    repeat (40) @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog, well above the roughly 6400 cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 5; a++) rdc(3'(a), a == 1 ? BAUD_RST : 8'h00);
    $display("test reset done");
    wr(ADDR_BAUD, 8'h01);
    wr(ADDR_MODE, 8'hF8);
    fork peer.grab(got); join_none
    wr(ADDR_TXS, 8'hA5);
    repeat (420) @(posedge clk);
    chk(got[8:1], 8'hA5);
    chk({5'h00, got[10:9], got[0]}, 8'h04);
    chk(8'(n_t), 8'h01);
    $display("test transmit done");
    // Every parity type, with a parity bit of 1 on two data parities
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 2; k++) begin
        d = 8'h3C | 8'(k);
        x = ((p == 3 && !(^d)) || (p == 2 && (^d))) ? STAT_PE : 8'h00;
        wr(ADDR_MODE, {2'b11, 2'(p), 4'b1000});
        fr(d, 1'b1);
        nr++;
        if (x != 8'h00) ne++;
        if (x != 8'h00) chk(8'(t_r - t_e), 8'h01);
        rdc(ADDR_STAT, x);
        rdc(ADDR_RXB, d);
        rdc(ADDR_STAT, 8'h00);
      end
    end
    $display("test parity done");
    wr(ADDR_MODE, 8'hC0);
    fr(8'hBC, 1'b1);
    nr++;
    rdc(ADDR_RXB, 8'h3C);
    wr(ADDR_MODE, 8'hCA);
    fr(8'h55, 1'b0);
    ne++;
    rdc(ADDR_STAT, STAT_FE);
    rdc(ADDR_RXB, 8'h55);
    chk(8'(n_r), 8'(nr));
    wr(ADDR_MODE, 8'hC8);
    fr(8'h11, 1'b1);
    fr(8'h22, 1'b1);
    nr += 2;
    ne++;
    rdc(ADDR_STAT, STAT_OE);
    rdc(ADDR_RXB, 8'h22);
    $display("test errors done");
    fork fr(8'h66, 1'b1); join_none
    repeat (150) @(posedge clk);
    wr(ADDR_MODE, 8'h88);
    repeat (300) @(posedge clk);
    chk(8'(n_r), 8'(nr));
    chk(8'(n_e), 8'(ne));
    rdc(ADDR_RXB, 8'h22);
    $display("test abort done");
    wr(ADDR_MODE, 8'h81);
    repeat (4) @(posedge clk);
    ir_on <= 1;
    wr(ADDR_TXS, 8'hF0);
    repeat (420) @(posedge clk);
    ir_on <= 0;
    chk(8'(n_rise), 8'h05);
    chk(8'(n_high), 8'h1E);
    chk(8'(n_t), 8'h02);
    chk(8'(n_e), 8'(ne));
    $display("test infrared done");
    wr(ADDR_MODE, 8'hC1);
    peer.ir_send({1'b1, 8'h3C, 1'b0});
    repeat (60) @(posedge clk);
    nr++;
    rdc(ADDR_STAT, 8'h00);
    rdc(ADDR_RXB, 8'h3C);
    chk(8'(n_r), 8'(nr));
    $display("test infrared receive done");
    tally_and_finish();
  end
endmodule
